// File: hw/lcf_cluster.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module lcf_cluster import lcf_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [LCF_ROWCLKS-1:0] row_clock,
	input wire logic [LCF_LOCAL_CTRL-1:0] local_ctrl,
	input wire logic device_wide_clear_n,
	input wire logic [LCF_CELLS*4-1:0] cell_data,
	input wire logic [LCF_CELLS-1:0] direct_left_in,
	input wire logic [LCF_CELLS-1:0] direct_right_in,
	input wire logic lut_chain_in,
	input wire logic reg_chain_in,
	input wire logic carry_in,
	output logic [LCF_CELLS*2-1:0] row_out,
	output logic [LCF_CELLS-1:0] local_out,
	output logic lut_chain_out,
	output logic reg_chain_out,
	output logic carry_out,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// configuration store
	logic [15:0] lut_mask [LCF_CELLS];
	logic [LCF_CFG_W-1:0] cell_cfg [LCF_CELLS];
	logic [19:0] in_sel [LCF_CELLS];
	logic [LCF_CTRLS*LCF_SEL_W-1:0] src_sel;
	logic dual_edge;

	// bus state
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic [32:0] wr_dec;
	logic [32:0] rd_dec;
	logic [31:0] wr_word;

	// fabric state
	logic dev_clr_meta;
	logic dev_clr_n_sync;
	logic [LCF_CTRLS-1:0] ctrl_line;
	logic [1:0] clk_prev;
	logic [1:0] tick;
	logic [LCF_BUS_W-1:0] local_bus;
	logic [LCF_CELLS*4-1:0] cell_din;
	logic [LCF_CELLS-1:0] cell_lut;
	logic [LCF_CELLS-1:0] cell_q;
	logic [LCF_CELLS-1:0] cell_cout;
	logic [LCF_CELLS:0] cell_cin;
	logic [LCF_CELLS-1:0] cell_tick;
	logic [LCF_CELLS-1:0] cell_aclr;
	logic [LCF_CELLS*3-1:0] cell_gen;

	// decode one address: bit 32 flags a mapped word, low bits the contents
	function automatic logic [32:0] lcf_decode(input logic [11:0] addr);
		logic [3:0] idx;
		logic [32:0] res;
		idx = 4'(addr[11:4] - LCF_CELL_BASE_IDX);
		res = {1'b1, 32'h0000_0000};
		if (addr == LCF_A_CTRL) begin
			res[0] = dual_edge;
		end else if (addr == LCF_A_SRC_LO) begin
			res[31:0] = src_sel[31:0];
		end else if (addr == LCF_A_SRC_HI) begin
			res[7:0] = src_sel[39:32];
		end else if (addr == LCF_A_STAT_Q) begin
			res[LCF_CELLS-1:0] = cell_q;
		end else if (addr == LCF_A_STAT_LUT) begin
			res[LCF_CELLS-1:0] = cell_lut;
		end else if (addr == LCF_A_STAT_CARRY) begin
			res[0] = cell_cout[LCF_CELLS-1];
		end else if (addr >= LCF_A_CELL0 && addr < LCF_A_CELL_END && addr[1:0] == 2'h0) begin
			if (addr[3:2] == LCF_CO_LUT) begin
				res[15:0] = lut_mask[idx];
			end else if (addr[3:2] == LCF_CO_CFG) begin
				res[LCF_CFG_W-1:0] = cell_cfg[idx];
			end else if (addr[3:2] == LCF_CO_ISEL) begin
				res[19:0] = in_sel[idx];
			end else begin
				res[32] = 1'b0;
			end
		end else begin
			res[32] = 1'b0;
		end
		return res;
	endfunction

	// a process, not an assign, so a stored word changing under a fixed address is seen
	always_comb begin
		wr_dec = lcf_decode(aw_addr);
		rd_dec = lcf_decode(s_axi_araddr);
	end
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// byte lanes merge the new data over the current word
	always_comb begin
		wr_word = wr_dec[31:0];
		for (int b = 0; b < 4; b++) begin
			if (w_strb[b]) begin
				wr_word[b*8 +: 8] = w_data[b*8 +: 8];
			end
		end
	end

	// write channels: address and data taken in either order, then one response
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= LCF_RESP_OKAY;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_dec[32] ? LCF_RESP_OKAY : LCF_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel: data captured at the address handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= LCF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_dec[31:0];
			s_axi_rresp <= rd_dec[32] ? LCF_RESP_OKAY : LCF_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// configuration writes; status words ignore writes
	always_ff @(posedge clk) begin
		if (rst) begin
			dual_edge <= 1'b0;
			src_sel <= LCF_RST_SRC;
			for (int i = 0; i < LCF_CELLS; i++) begin
				lut_mask[i] <= LCF_RST_LUT;
				cell_cfg[i] <= LCF_RST_CFG;
				in_sel[i] <= LCF_RST_ISEL;
			end
		end else if (wr_go && wr_dec[32]) begin
			if (aw_addr == LCF_A_CTRL) begin
				dual_edge <= wr_word[0];
			end else if (aw_addr == LCF_A_SRC_LO) begin
				src_sel[31:0] <= wr_word;
			end else if (aw_addr == LCF_A_SRC_HI) begin
				src_sel[39:32] <= wr_word[7:0];
			end else if (aw_addr >= LCF_A_CELL0) begin
				if (aw_addr[3:2] == LCF_CO_LUT) begin
					lut_mask[4'(aw_addr[11:4] - LCF_CELL_BASE_IDX)] <= wr_word[15:0];
				end else if (aw_addr[3:2] == LCF_CO_CFG) begin
					cell_cfg[4'(aw_addr[11:4] - LCF_CELL_BASE_IDX)] <= wr_word[LCF_CFG_W-1:0];
				end else begin
					in_sel[4'(aw_addr[11:4] - LCF_CELL_BASE_IDX)] <= wr_word[19:0];
				end
			end
		end
	end

	// device clear comes from a pin; synchronised, released high
	always_ff @(posedge clk) begin
		if (rst) begin
			dev_clr_meta <= 1'b1;
			dev_clr_n_sync <= 1'b1;
		end else begin
			dev_clr_meta <= device_wide_clear_n;
			dev_clr_n_sync <= dev_clr_meta;
		end
	end

	lcf_ctrl_gen u_ctrl (
		.clk(clk),
		.rst(rst),
		.row_clock(row_clock),
		.local_ctrl(local_ctrl),
		.src_sel(src_sel),
		.dual_edge(dual_edge),
		.ctrl_line(ctrl_line)
	);

	// cluster clock edges; the enable of the same pair gates each one
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_prev <= 2'b00;
		end else begin
			clk_prev <= {ctrl_line[LCF_C_CLK2], ctrl_line[LCF_C_CLK1]};
		end
	end

	assign tick[0] = ctrl_line[LCF_C_CLK1] & ~clk_prev[0] & ctrl_line[LCF_C_ENA1];
	assign tick[1] = ctrl_line[LCF_C_CLK2] & ~clk_prev[1] & ctrl_line[LCF_C_ENA2];

	// shared routing pool: own local outputs plus both direct links
	assign local_bus = {direct_right_in, direct_left_in, local_out};
	// subtraction forces the first carry-in; the adder LSB must sit in cell 0
	assign cell_cin[0] = ctrl_line[LCF_C_ADDSUB] | carry_in;

	// ten cells joined by table, register and carry chains
	for (genvar i = 0; i < LCF_CELLS; i++) begin : g_cell
		logic [3:0] din;

		// each data input picks an external line or a local pool line
		always_comb begin
			din = 4'h0;
			for (int k = 0; k < 4; k++) begin
				if (in_sel[i][k*LCF_ISEL_W +: LCF_ISEL_W] == LCF_ISEL_EXT) begin
					din[k] = cell_data[i*4+k];
				end else if (in_sel[i][k*LCF_ISEL_W +: LCF_ISEL_W] < 5'(LCF_BUS_W)) begin
					din[k] = local_bus[in_sel[i][k*LCF_ISEL_W +: LCF_ISEL_W]];
				end
			end
		end

		assign cell_din[i*4 +: 4] = din;
		assign cell_tick[i] = tick[cell_cfg[i][LCF_CF_CLK]];
		assign cell_aclr[i] = cell_cfg[i][LCF_CF_ACLR] ? ctrl_line[LCF_C_ACLR2]
			: ctrl_line[LCF_C_ACLR1];

		lcf_cell u_cell (
			.clk(clk),
			.rst(rst),
			.lut_mask(lut_mask[i]),
			.cfg(cell_cfg[i]),
			.din(din),
			.lut_chain_in(i == 0 ? lut_chain_in : cell_lut[(i+LCF_CELLS-1)%LCF_CELLS]),
			.reg_chain_in(i == 0 ? reg_chain_in : cell_q[(i+LCF_CELLS-1)%LCF_CELLS]),
			.cin(cell_cin[i]),
			.b_inv(ctrl_line[LCF_C_ADDSUB]),
			.tick(cell_tick[i]),
			.aclr(cell_aclr[i]),
			.aload(ctrl_line[LCF_C_ALOAD]),
			.sclr(ctrl_line[LCF_C_SCLR]),
			.sload(ctrl_line[LCF_C_SLOAD]),
			.dev_clr_n(dev_clr_n_sync),
			.lut_out(cell_lut[i]),
			.q(cell_q[i]),
			.cout(cell_cout[i]),
			.gen_out(cell_gen[i*3 +: 3])
		);

		assign cell_cin[i+1] = cell_cout[i];
	end

	// registered cell outputs: two to routing, one to the local pool
	always_ff @(posedge clk) begin
		if (rst) begin
			row_out <= '0;
			local_out <= '0;
			lut_chain_out <= 1'b0;
			reg_chain_out <= 1'b0;
			carry_out <= 1'b0;
		end else begin
			for (int i = 0; i < LCF_CELLS; i++) begin
				row_out[i*2 +: 2] <= cell_gen[i*3 +: 2];
				local_out[i] <= cell_gen[i*3+2];
			end
			lut_chain_out <= cell_lut[LCF_CELLS-1];
			reg_chain_out <= cell_q[LCF_CELLS-1];
			carry_out <= cell_cout[LCF_CELLS-1];
		end
	end

	default clocking lcf_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_CLEAR_WINS: assert property (
		(cell_aclr[0] && ctrl_line[LCF_C_ALOAD]) |=> !cell_q[0])
		else $error("async clear lost to preset/load");
	AST_DEV_CLEAR: assert property (
		(!dev_clr_n_sync && ctrl_line[LCF_C_ALOAD]) |=> (cell_q == '0))
		else $error("device clear did not reset all registers");
	AST_PRESET: assert property (
		(ctrl_line[LCF_C_ALOAD] && !cell_aclr[0] && dev_clr_n_sync && cell_din[3])
		|=> cell_q[0])
		else $error("async load of high did not preset");
	AST_HOLD: assert property (
		(!cell_tick[0] && !cell_aclr[0] && !ctrl_line[LCF_C_ALOAD] && dev_clr_n_sync)
		|=> $stable(cell_q[0]))
		else $error("register moved without its clock");
	AST_ENA_GATES: assert property (
		!ctrl_line[LCF_C_ENA1] |-> !tick[0])
		else $error("clock one ran with enable one low");
	AST_TICK_EDGE: assert property (
		tick[0] |-> (ctrl_line[LCF_C_CLK1] && !$past(ctrl_line[LCF_C_CLK1])))
		else $error("tick without a rising edge of clock one");
	AST_DUAL_EDGE: assert property (
		(dual_edge && $stable(dual_edge)) |-> (ctrl_line[LCF_C_CLK2] != ctrl_line[LCF_C_CLK1]))
		else $error("clock two not the inverse of clock one");
	AST_SUB_SUM: assert property (
		(cell_cfg[0][LCF_CF_ARITH] && ctrl_line[LCF_C_ADDSUB])
		|-> (cell_cin[0] && cell_lut[0] == (cell_din[0] ^ ~cell_din[1] ^ 1'b1)))
		else $error("subtract did not add the complement");
	AST_REG_CHAIN: assert property (
		(cell_cfg[1][LCF_CF_RCHAIN] && cell_cfg[1][1:0] == LCF_FF_D && cell_tick[1]
		&& !cell_aclr[1] && !ctrl_line[LCF_C_ALOAD] && !ctrl_line[LCF_C_SCLR]
		&& !ctrl_line[LCF_C_SLOAD] && dev_clr_n_sync) |=> (cell_q[1] == $past(cell_q[0])))
		else $error("register chain did not shift");
	AST_OUT_SEL: assert property (
		cell_cfg[0][LCF_CF_OSEL] |=> (row_out[0] == $past(cell_q[0])))
		else $error("output did not follow the register");
	AST_B_HOLD: assert property (
		(s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
		else $error("write response dropped early");
endmodule // lcf_cluster
`default_nettype wire

// File: hw/lcf_pkg.sv
package lcf_pkg;
	localparam int LCF_CELLS = 10;
	localparam int LCF_CTRLS = 10;
	localparam int LCF_ROWCLKS = 8;
	localparam int LCF_LOCAL_CTRL = 8;
	localparam int LCF_SEL_W = 4;
	localparam int LCF_BUS_W = 30;
	localparam int LCF_ISEL_W = 5;
	localparam logic [4:0] LCF_ISEL_EXT = 5'h1F;
	// control line indices
	localparam int LCF_C_CLK1 = 0;
	localparam int LCF_C_CLK2 = 1;
	localparam int LCF_C_ENA1 = 2;
	localparam int LCF_C_ENA2 = 3;
	localparam int LCF_C_ACLR1 = 4;
	localparam int LCF_C_ACLR2 = 5;
	localparam int LCF_C_SCLR = 6;
	localparam int LCF_C_ALOAD = 7;
	localparam int LCF_C_SLOAD = 8;
	localparam int LCF_C_ADDSUB = 9;
	// cell configuration fields
	localparam int LCF_CF_FF = 0;
	localparam int LCF_CF_CLK = 2;
	localparam int LCF_CF_ACLR = 3;
	localparam int LCF_CF_ARITH = 4;
	localparam int LCF_CF_LCHAIN = 5;
	localparam int LCF_CF_FBACK = 6;
	localparam int LCF_CF_RCHAIN = 7;
	localparam int LCF_CF_OSEL = 8;
	localparam int LCF_CFG_W = 11;
	// register map, byte addresses
	localparam logic [11:0] LCF_A_CTRL = 12'h000;
	localparam logic [11:0] LCF_A_SRC_LO = 12'h004;
	localparam logic [11:0] LCF_A_SRC_HI = 12'h008;
	localparam logic [11:0] LCF_A_STAT_Q = 12'h00C;
	localparam logic [11:0] LCF_A_STAT_LUT = 12'h010;
	localparam logic [11:0] LCF_A_STAT_CARRY = 12'h014;
	localparam logic [11:0] LCF_A_CELL0 = 12'h040;
	localparam logic [11:0] LCF_A_CELL_END = 12'h0E0;
	localparam logic [7:0] LCF_CELL_BASE_IDX = 8'h04;
	localparam logic [1:0] LCF_CO_LUT = 2'h0;
	localparam logic [1:0] LCF_CO_CFG = 2'h1;
	localparam logic [1:0] LCF_CO_ISEL = 2'h2;
	// reset values
	localparam logic [15:0] LCF_RST_LUT = 16'h0000;
	localparam logic [10:0] LCF_RST_CFG = 11'h000;
	localparam logic [19:0] LCF_RST_ISEL = 20'hFFFFF;
	localparam logic [39:0] LCF_RST_SRC = 40'h0000000000;
	localparam logic [1:0] LCF_RESP_OKAY = 2'h0;
	localparam logic [1:0] LCF_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		LCF_FF_D = 2'b00,
		LCF_FF_T = 2'b01,
		LCF_FF_JK = 2'b10,
		LCF_FF_SR = 2'b11
	} lcf_ff_type;
endpackage

// File: hw/lcf_ctrl_gen.sv
`timescale 1ns/1ns
`default_nettype none
module lcf_ctrl_gen import lcf_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [LCF_ROWCLKS-1:0] row_clock,
	input wire logic [LCF_LOCAL_CTRL-1:0] local_ctrl,
	input wire logic [LCF_CTRLS*LCF_SEL_W-1:0] src_sel,
	input wire logic dual_edge,
	output logic [LCF_CTRLS-1:0] ctrl_line
);
	logic [LCF_ROWCLKS-1:0] row_meta;
	logic [LCF_ROWCLKS-1:0] row_sync;
	logic [15:0] pool;

	// row clocks arrive from pins; two flops before anything looks at them
	always_ff @(posedge clk) begin
		if (rst) begin
			row_meta <= '0;
			row_sync <= '0;
		end else begin
			row_meta <= row_clock;
			row_sync <= row_meta;
		end
	end

	assign pool = {local_ctrl, row_sync};

	// one selector per control line, so no more than ten exist
	for (genvar g = 0; g < LCF_CTRLS; g++) begin : g_sel
		if (g == LCF_C_CLK2) begin : g_two
			// both edges wanted: clock two becomes clock one inverted
			assign ctrl_line[g] = dual_edge ? ~pool[src_sel[LCF_C_CLK1*LCF_SEL_W +: LCF_SEL_W]]
				: pool[src_sel[g*LCF_SEL_W +: LCF_SEL_W]];
		end else begin : g_one
			assign ctrl_line[g] = pool[src_sel[g*LCF_SEL_W +: LCF_SEL_W]];
		end
	end
endmodule // lcf_ctrl_gen
`default_nettype wire

// File: hw/lcf_cell.sv
`timescale 1ns/1ns
`default_nettype none
module lcf_cell import lcf_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] lut_mask,
	input wire logic [LCF_CFG_W-1:0] cfg,
	input wire logic [3:0] din,
	input wire logic lut_chain_in,
	input wire logic reg_chain_in,
	input wire logic cin,
	input wire logic b_inv,
	input wire logic tick,
	input wire logic aclr,
	input wire logic aload,
	input wire logic sclr,
	input wire logic sload,
	input wire logic dev_clr_n,
	output logic lut_out,
	output logic q,
	output logic cout,
	output logic [2:0] gen_out
);
	logic [3:0] lut_idx;
	logic b_bit;
	logic sum;
	logic d_src;

	// table inputs: chain replaces input three, own register replaces input four
	assign lut_idx = {cfg[LCF_CF_FBACK] ? q : din[3],
		cfg[LCF_CF_LCHAIN] ? lut_chain_in : din[2], din[1], din[0]};
	assign b_bit = din[1] ^ b_inv;
	assign sum = din[0] ^ b_bit ^ cin;
	assign cout = (din[0] & b_bit) | (cin & (din[0] ^ b_bit));
	assign lut_out = cfg[LCF_CF_ARITH] ? sum : lut_mask[lut_idx];
	assign d_src = cfg[LCF_CF_RCHAIN] ? reg_chain_in : lut_out;

	// each output picks table or register on its own
	for (genvar k = 0; k < 3; k++) begin : g_out
		assign gen_out[k] = cfg[LCF_CF_OSEL+k] ? q : lut_out;
	end

	// clear classes in priority order; clear, load and device clear act without its tick, the rest only on its tick
	always_ff @(posedge clk) begin
		if (rst || !dev_clr_n) begin
			q <= 1'b0;
		end else if (aclr) begin
			q <= 1'b0;
		end else if (aload) begin
			q <= din[3];
		end else if (tick) begin
			if (sclr) begin
				q <= 1'b0;
			end else if (sload) begin
				q <= din[3];
			end else begin
				case (lcf_ff_type'(cfg[LCF_CF_FF +: 2]))
					LCF_FF_D: q <= d_src;
					LCF_FF_T: q <= q ^ d_src;
					LCF_FF_JK: q <= (d_src & ~q) | (~din[1] & q);
					default: q <= d_src | (q & ~din[1]);
				endcase
			end
		end
	end
endmodule // lcf_cell
`default_nettype wire

// File: test/lcf_nbr_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side of the cluster: row clock source and the two neighbouring clusters
module lcf_nbr_model import lcf_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [6:0] row_lvl,
	input wire logic [LCF_CELLS-1:0] left_val,
	input wire logic [LCF_CELLS-1:0] local_out,
	output logic [LCF_ROWCLKS-1:0] row_clock,
	output logic [LCF_CELLS-1:0] direct_left_in,
	output logic [LCF_CELLS-1:0] direct_right_in
);
	logic [1:0] cnt;
	logic phase;
	// row clock zero toggles every four cycles while run is high, stands still otherwise
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 2'h0;
			phase <= 1'h0;
		end else if (run) begin
			cnt <= cnt + 2'h1;
			if (cnt == 2'h3) phase <= ~phase;
		end
	end
	// upper row clocks are plain levels chosen by the bench
	assign row_clock = {row_lvl, phase};
	assign direct_left_in = left_val;
	// right neighbour registers our local lines, one cycle late as a real cell would
	always_ff @(posedge clk) begin
		direct_right_in <= rst ? '0 : local_out;
	end
endmodule // lcf_nbr_model
`default_nettype wire

// File: test/tb_logic_cluster_fabric.sv
`timescale 1ns/1ns
`default_nettype none
module tb_logic_cluster_fabric import lcf_pkg::*;;
	localparam logic [15:0] M = 16'hA5C3;
	localparam logic [9:0] LD = 10'h155;
	localparam logic [9:0] STEPS = 10'h365;
	localparam logic [21:0] CASES [4] = '{{2'h0, 10'h3FF, 10'h001}, {2'h1, 10'h005, 10'h007},
		{2'h1, 10'h200, 10'h100}, {2'h2, 10'h123, 10'h045}};
	logic clk = 1'h0;
	logic rst, run, device_wide_clear_n, lut_chain_in, reg_chain_in, carry_in;
	logic [6:0] row_lvl;
	logic [7:0] local_ctrl, row_clock;
	logic [39:0] cell_data, cd;
	logic [9:0] left_val, direct_left_in, direct_right_in, local_out, e, a, b;
	logic [19:0] row_out;
	logic lut_chain_out, reg_chain_out, carry_out, ci, sub, qm, j, k;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [10:0] sum;
	int fail_count = 0;
	int tests_run = 0;
	// 125 MHz
	always #4 clk = ~clk;
	lcf_cluster i_dut (.clk, .rst, .row_clock, .local_ctrl, .device_wide_clear_n, .cell_data,
		.direct_left_in, .direct_right_in, .lut_chain_in, .reg_chain_in, .carry_in, .row_out,
		.local_out, .lut_chain_out, .reg_chain_out, .carry_out, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	lcf_nbr_model i_nbr (.clk, .rst, .run, .row_lvl, .left_val, .local_out, .row_clock,
		.direct_left_in, .direct_right_in);
	task automatic complete_run;
		if (fail_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask
	// one write; address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic got;
		logic [1:0] r;
		n = 0;
		got = 1'h0;
		r = 2'h3;
		@(posedge clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!got && n < 50) begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				got = 1'h1;
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
			end
		end
		chk({31'h0, got}, 32'h1);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [11:0] ad, input logic [31:0] x, input logic [1:0] er);
		int n;
		logic got;
		logic [1:0] r;
		logic [31:0] d;
		n = 0;
		got = 1'h0;
		r = 2'h3;
		d = 32'h0;
		@(posedge clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!got && n < 50) begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				got = 1'h1;
				r = s_axi_rresp;
				d = s_axi_rdata;
				s_axi_rready <= 1'h0;
			end
		end
		chk({31'h0, got}, 32'h1);
		chk(d, x);
		chk({30'h0, r}, {30'h0, er});
	endtask
	function automatic logic [11:0] cfg_at(input int i);
		return LCF_A_CELL0 + 12'(16 * i + 4);
	endfunction
	// register outputs as shown on output zero of each cell
	function automatic logic [31:0] shown();
		logic [31:0] f;
		f = 32'h0;
		for (int i = 0; i < 10; i++) f[i] = row_out[2 * i];
		return f;
	endfunction
	// exactly one rising edge of row clock zero, then time for it to reach the outputs
	task automatic pulse;
		@(posedge clk);
		run <= 1'h1;
		@(posedge row_clock[0]);
		@(posedge clk);
		run <= 1'h0;
		repeat (6) @(posedge clk);
	endtask
	task automatic clr;
		@(posedge clk);
		local_ctrl[4] <= 1'h1;
		repeat (2) @(posedge clk);
		local_ctrl[4] <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	// hang guard, far beyond the thousand or so cycles the sequence needs
	initial begin
		#400000;
		fail_count++;
		complete_run();
	end
	// main sequence
	initial begin
		{rst, device_wide_clear_n, s_axi_wstrb} = 6'h3F;
		{run, lut_chain_in, reg_chain_in, carry_in, row_lvl, local_ctrl, cell_data} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		left_val = 10'h2A5;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(LCF_A_CTRL, 32'h0, LCF_RESP_OKAY);
		rd(LCF_A_CELL0 + 12'h008, {12'h0, LCF_RST_ISEL}, LCF_RESP_OKAY);
		rd(LCF_A_CELL0 + 12'h00C, 32'h0, LCF_RESP_SLVERR);
		wr(LCF_A_CELL_END, 32'hFFFFFFFF, LCF_RESP_SLVERR);
		wr(LCF_A_STAT_Q, 32'hFFFFFFFF, LCF_RESP_OKAY);
		rd(LCF_A_STAT_Q, 32'h0, LCF_RESP_OKAY);
		// clock one from row clock zero, sload and addsub from row levels, the rest local
		wr(LCF_A_SRC_LO, 32'hFEDCBA90, LCF_RESP_OKAY);
		wr(LCF_A_SRC_HI, 32'h00000067, LCF_RESP_OKAY);
		rd(LCF_A_SRC_HI, 32'h00000067, LCF_RESP_OKAY);
		// every table index of cell zero, cell one takes cell zero's table on its third input
		wr(LCF_A_CELL0, {16'h0, M}, LCF_RESP_OKAY);
		wr(LCF_A_CELL0 + 12'h010, 32'h0000F0F0, LCF_RESP_OKAY);
		wr(cfg_at(1), 32'h00000020, LCF_RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			cell_data[3:0] <= i[3:0];
			repeat (3) @(posedge clk);
			chk({29'h0, row_out[1:0], local_out[0]}, {29'h0, {3{M[i]}}});
			rd(LCF_A_STAT_LUT, {30'h0, {2{M[i]}}}, LCF_RESP_OKAY);
		end
		// adder and subtractor across all ten cells, least significant bit in cell zero
		for (int i = 0; i < 10; i++) wr(cfg_at(i), 32'h00000010, LCF_RESP_OKAY);
		for (int c = 0; c < 4; c++) begin
			{ci, sub, a, b} = CASES[c];
			cd = '0;
			for (int i = 0; i < 10; i++) {cd[4 * i + 1], cd[4 * i]} = {b[i], a[i]};
			@(posedge clk);
			row_lvl[5] <= sub;
			carry_in <= ci;
			cell_data <= cd;
			repeat (8) @(posedge clk);
			sum = {1'h0, a} + {1'h0, sub ? ~b : b} + {10'h0, sub | ci};
			chk(shown() | {21'h0, carry_out, 10'h0}, {21'h0, sum});
			chk({31'h0, lut_chain_out}, {31'h0, sum[9]});
		end
		// shift chain through the registers while cell zero's table stays in use
		for (int i = 0; i < 10; i++) wr(cfg_at(i), 32'h00000180, LCF_RESP_OKAY);
		@(posedge clk);
		row_lvl[5] <= 1'h0;
		carry_in <= 1'h0;
		cell_data <= 40'h1;
		local_ctrl[2] <= 1'h1;
		for (int s = 0; s < 10; s++) begin
			@(posedge clk);
			reg_chain_in <= LD[s] ^ s[1];
			pulse();
		end
		for (int i = 0; i < 10; i++) e[i] = LD[9 - i] ^ 1'((9 - i) / 2 % 2);
		chk(shown(), {22'h0, e});
		chk({30'h0, reg_chain_out, row_out[1]}, {30'h0, e[9], M[1]});
		// with enable one low further row clock edges must not move anything
		@(posedge clk);
		local_ctrl[2] <= 1'h0;
		reg_chain_in <= ~e[0];
		pulse();
		pulse();
		chk(shown(), {22'h0, e});
		// load from input four, clear beats load, device clear beats all
		cd = cell_data;
		for (int i = 0; i < 10; i++) cd[4 * i + 3] = LD[i];
		@(posedge clk);
		cell_data <= cd;
		local_ctrl[7] <= 1'h1;
		repeat (4) @(posedge clk);
		chk(shown(), {22'h0, LD});
		local_ctrl[4] <= 1'h1;
		repeat (4) @(posedge clk);
		chk(shown(), 32'h0);
		local_ctrl[4] <= 1'h0;
		device_wide_clear_n <= 1'h0;
		repeat (6) @(posedge clk);
		chk(shown(), 32'h0);
		device_wide_clear_n <= 1'h1;
		local_ctrl[7] <= 1'h0;
		local_ctrl[2] <= 1'h1;
		// each register kind on cell zero, data from its table which passes input one
		wr(LCF_A_CELL0, 32'h0000AAAA, LCF_RESP_OKAY);
		for (int md = 0; md < 4; md++) begin
			wr(cfg_at(0), 32'h100 | md, LCF_RESP_OKAY);
			clr();
			qm = 1'h0;
			for (int s = 0; s < 5; s++) begin
				{k, j} = STEPS[2 * s +: 2];
				@(posedge clk);
				cell_data[1:0] <= {k, j};
				pulse();
				case (md)
					0: qm = j;
					1: qm = qm ^ j;
					2: qm = (j & k) ? ~qm : (j ? 1'h1 : (k ? 1'h0 : qm));
					default: qm = j ? 1'h1 : (k ? 1'h0 : qm);
				endcase
				if (md != 3 || !(j & k)) chk({31'h0, row_out[0]}, {31'h0, qm});
			end
		end
		// register fed back into its own table as input four, table inverts it
		wr(LCF_A_CELL0, 32'h000000FF, LCF_RESP_OKAY);
		wr(cfg_at(0), 32'h00000140, LCF_RESP_OKAY);
		clr();
		for (int s = 1; s < 4; s++) begin
			pulse();
			chk({31'h0, row_out[0]}, {31'h0, s[0]});
		end
		// clock two as clock one's source inverted: falling row edges toggle cell zero
		wr(LCF_A_CTRL, 32'h00000001, LCF_RESP_OKAY);
		wr(cfg_at(0), 32'h00000144, LCF_RESP_OKAY);
		local_ctrl[3] <= 1'h1;
		for (int s = 0; s < 2; s++) begin
			pulse();
			chk({31'h0, row_out[0]}, {31'h0, s[0]});
		end
		// two ticks each, so a plain toggle cannot pass for sync clear or sync load
		local_ctrl[6] <= 1'h1;
		pulse();
		pulse();
		chk({31'h0, row_out[0]}, 32'h0);
		local_ctrl[6] <= 1'h0;
		row_lvl[6] <= 1'h1;
		pulse();
		pulse();
		chk({31'h0, row_out[0]}, 32'h1);
		row_lvl[6] <= 1'h0;
		// cell three reads left link, right link and a local line; cell one's table drives both
		wr(LCF_A_CELL0 + 12'h030, 32'h00002000, LCF_RESP_OKAY);
		wr(LCF_A_CELL0 + 12'h038, 32'h0000D56A, LCF_RESP_OKAY);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk);
			cell_data[6] <= v[0];
			repeat (4) @(posedge clk);
			chk({31'h0, row_out[7]}, {31'h0, v[0]});
		end
		complete_run();
	end
endmodule // tb_logic_cluster_fabric
`default_nettype wire
